// ==== sfspi_front.sv ====
// sfspi_front: serial flash link front end, instruction shifting and write gating.
// assumes an array engine outside that reads combinationally at readAddr,
// executes cmd pulses, raises busy while working and pulses opDone at the end.
// Functional notes
// - single-line instruction, address and write bits are taken on clock rises
// - read and status bits are driven out on clock falls
// - clock modes 0 and 3 both work; only those two are used
// - dual read instructions move two bits per clock on IO0 and IO1
// - quad read instructions move four bits per clock on IO0 to IO3
// - quad instructions need the quad enable bit set first
// - pause works only while the quad enable bit is clear, ignored whenever it is set
// - pause begins on pin fall with clock low, else after next clock fall
// - pause ends on pin rise with clock low, else after next clock fall
// - while paused, output floats and clock and input are ignored
// - pause keeps the partial instruction and buffered data intact
// - during power-on reset nothing runs and nothing is decoded
// - after reset, write-type instructions are refused for a power-up delay
// - after power-up the write enable latch is clear
// - program, erase and status write need the write enable latch set
// - the latch clears when any program, erase or status write completes
// - protect settings can make one sector up to the whole array read only
// - write-protect pin and status protect settings gate status writes
// - in power-down only the release instruction is obeyed
// - with quad enable clear, status protect set and write-protect pin low refuse status writes
// - deselected, every data output floats
module sfspi_front
   import sfspi_pkg::*;
#(
   parameter int PUW_COUNT = PUW_CYCLES
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic csN,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   input wire logic quadEnable,
   input wire logic statusProtectBit,
   input wire logic statusLockBit,
   input wire sfspi_prot_type prot,
   input wire logic busy,
   input wire logic opDone,
   input wire logic [7:0] readData,
   output logic [ADDR_W-1:0] readAddr,
   output logic [7:0] wrByte,
   output logic wrByteValid,
   output sfspi_cmd_type cmd,
   output logic writeEnableLatch,
   output logic poweredDown,
   output logic writeInhibit,
   output logic paused
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic sfspi_opinfo_type decodeOp(input logic [7:0] op);
      sfspi_opinfo_type r;
      r = '{kind: K_NONE, aLanes: LANE_X1, dummy: DUMMY_NONE, dLanes: LANE_X1,
         needWen: 1'b0, needQuad: 1'b0};
      case (op)
         OP_WREN, OP_WRDI, OP_PDOWN, OP_RPD: r.kind = K_CTRL;
         OP_RDSR: r.kind = K_STAT;
         OP_WRSR: begin
            r.kind = K_WSTAT;
            r.needWen = 1'b1;
         end
         OP_READ: r.kind = K_READ;
         OP_FAST: begin
            r.kind = K_READ;
            r.dummy = DUMMY_FAST;
         end
         OP_DOUT: begin
            r.kind = K_READ;
            r.dummy = DUMMY_FAST;
            r.dLanes = LANE_X2;
         end
         OP_DIO: begin
            r.kind = K_READ;
            r.aLanes = LANE_X2;
            r.dummy = DUMMY_DIO;
            r.dLanes = LANE_X2;
         end
         OP_QOUT: begin
            r.kind = K_READ;
            r.dummy = DUMMY_FAST;
            r.dLanes = LANE_X4;
            r.needQuad = 1'b1;
         end
         OP_QIO: begin
            r.kind = K_READ;
            r.aLanes = LANE_X4;
            r.dummy = DUMMY_QIO;
            r.dLanes = LANE_X4;
            r.needQuad = 1'b1;
         end
         OP_PROG: begin
            r.kind = K_PROG;
            r.needWen = 1'b1;
         end
         OP_SE4, OP_BE32, OP_BE64, OP_CE: begin
            r.kind = K_ERASE;
            r.needWen = 1'b1;
         end
         default: r.kind = K_NONE;
      endcase
      return r;
   endfunction : decodeOp

   // most significant bit arrives first, so new bits enter at the bottom
   function automatic logic [31:0] shiftIn(input logic [31:0] sh, input logic [3:0] io,
      input logic [2:0] lanes);
      case (lanes)
         LANE_X2: return {sh[29:0], io[1:0]};
         LANE_X4: return {sh[27:0], io};
         default: return {sh[30:0], io[0]};
      endcase
   endfunction : shiftIn

   function automatic logic [3:0] laneOut(input logic [7:0] b, input logic [2:0] lanes);
      case (lanes)
         LANE_X2: return {2'b00, b[7:6]};
         LANE_X4: return b[7:4];
         default: return {2'b00, b[7], 1'b0};
      endcase
   endfunction : laneOut

   function automatic logic [3:0] laneMask(input logic [2:0] lanes);
      case (lanes)
         LANE_X2: return 4'h3;
         LANE_X4: return 4'hf;
         default: return 4'h2;
      endcase
   endfunction : laneMask

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      sfspi_state_type st;
      sfspi_opinfo_type info;
      logic [7:0] op;
      logic [4:0] cnt;
      logic [31:0] sh;
      logic [ADDR_W-1:0] addr;
      logic [7:0] outSh;
      logic [2:0] outCnt;
      logic gotByte;
      logic [7:0] stData;
      logic sclkPrev;
      logic csPrev;
      logic wen;
      logic pd;
      logic [PUW_W-1:0] puw;
      logic inhibit;
      logic [3:0] ioOut;
      logic [3:0] ioOe;
      logic [7:0] wrByte;
      logic wrValid;
      sfspi_cmd_type cmd;
   } sfspi_front_type;

   localparam sfspi_front_type RESET_S = '{
      st: ST_CMD,
      info: '{kind: K_NONE, aLanes: LANE_X1, dummy: DUMMY_NONE, dLanes: LANE_X1,
         needWen: 1'b0, needQuad: 1'b0},
      op: 8'h00, cnt: 5'h00, sh: 32'h0, addr: 24'h0, outSh: 8'h00, outCnt: 3'h0,
      gotByte: 1'b0, stData: 8'h00, sclkPrev: 1'b0, csPrev: 1'b1,
      wen: 1'b0,
      pd: 1'b0, puw: PUW_COUNT[PUW_W-1:0], inhibit: 1'b1,
      ioOut: 4'h0, ioOe: 4'h0, wrByte: 8'h00, wrValid: 1'b0,
      cmd: '{valid: 1'b0, opcode: 8'h00, addr: 24'h0, data: 8'h00}};

   sfspi_front_type s;
   sfspi_front_type next_s;
   sfspi_opinfo_type info;
   logic holdPaused;
   logic protHit;
   logic protAny;
   logic wpN;
   logic rise;
   logic fall;
   logic deselect;
   logic [31:0] shNext;
   logic [4:0] cntNext;
   logic [7:0] outByte;
   logic [7:0] statusByte;
   logic statusWriteOk;

   // ------------------------------------------------------------
   // pause and protection
   // ------------------------------------------------------------
   sfspi_hold u_hold (
      .mclk(mclk),
      .rst_b(rst_b),
      .sclk(sclk),
      .csN(csN),
      .holdN(ioIn[3]),
      .enable(!quadEnable),
      .paused(holdPaused)
   );

   sfspi_protect u_protect (
      .addr(s.addr[ARRAY_W-1:0]),
      .prot(prot),
      .hit(protHit),
      .anyHit(protAny)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      info = decodeOp(s.sh[7:0]);
      wpN = quadEnable | ioIn[2];
      // paused: clock and data pins are ignored, state is frozen
      rise = sclk && !s.sclkPrev && !csN && !holdPaused;
      fall = !sclk && s.sclkPrev && !csN && !holdPaused;
      deselect = csN && !s.csPrev;
      shNext = shiftIn(s.sh, ioIn, (s.st == ST_ADDR) ? s.info.aLanes : LANE_X1);
      cntNext = s.cnt + ((s.st == ST_ADDR) ? {2'b00, s.info.aLanes} : 5'h01);
      statusByte = {statusProtectBit, prot.granularity, prot.topBottom, prot.range,
         s.wen, busy};
      statusWriteOk = !statusLockBit && !(statusProtectBit && !wpN);
      outByte = (s.outCnt == 3'h0) ?
         ((s.info.kind == K_STAT) ? statusByte : readData) : s.outSh;

      next_s.sclkPrev = sclk;
      next_s.csPrev = csN;
      next_s.wrValid = 1'b0;
      next_s.cmd.valid = 1'b0;
      if (s.puw != '0) begin
         next_s.puw = s.puw - 1'b1;
      end
      next_s.inhibit = (next_s.puw != '0);
      if (opDone) begin
         next_s.wen = 1'b0;
      end

      if (csN) begin
         next_s.ioOe = 4'h0;
      end else if (holdPaused) begin
         next_s.ioOe = 4'h0;
      end

      case (s.st)
         ST_CMD: begin
            if (rise) begin
               next_s.sh = shNext;
               next_s.cnt = cntNext;
               if (cntNext == BYTE_BITS) begin
                  next_s.cnt = 5'h00;
                  next_s.op = shNext[7:0];
                  next_s.info = decodeOp(shNext[7:0]);
                  info = decodeOp(shNext[7:0]);
                  next_s.gotByte = 1'b0;
                  next_s.outCnt = 3'h0;
                  if (s.pd && shNext[7:0] != OP_RPD) begin
                     next_s.st = ST_SKIP;
                  end else if (busy && shNext[7:0] != OP_RDSR) begin
                     next_s.st = ST_SKIP;
                  end else if (info.kind == K_NONE) begin
                     next_s.st = ST_SKIP;
                  end else if (info.needQuad && !quadEnable) begin
                     next_s.st = ST_SKIP;
                  end else if ((info.needWen && !s.wen) || (s.puw != '0 &&
                     (info.needWen || shNext[7:0] == OP_WREN))) begin
                     next_s.st = ST_SKIP;
                  end else begin
                     case (info.kind)
                        K_STAT: begin
                           next_s.st = ST_RDATA;
                           next_s.info.dLanes = LANE_X1;
                        end
                        K_WSTAT: next_s.st = ST_WDATA;
                        K_READ, K_PROG: next_s.st = ST_ADDR;
                        K_ERASE: next_s.st = (shNext[7:0] == OP_CE) ? ST_DONE : ST_ADDR;
                        default: next_s.st = ST_DONE;
                     endcase
                  end
               end
            end
         end
         ST_ADDR: begin
            if (rise) begin
               next_s.sh = shNext;
               next_s.cnt = cntNext;
               if (cntNext == ADDR_BITS) begin
                  next_s.cnt = 5'h00;
                  next_s.addr = shNext[ADDR_W-1:0];
                  if (s.info.kind == K_PROG) begin
                     next_s.st = ST_WDATA;
                  end else if (s.info.kind == K_ERASE) begin
                     next_s.st = ST_DONE;
                  end else if (s.info.dummy != DUMMY_NONE) begin
                     next_s.st = ST_DUMMY;
                  end else begin
                     next_s.st = ST_RDATA;
                  end
               end
            end
         end
         ST_DUMMY: begin
            if (rise) begin
               next_s.cnt = cntNext;
               if (cntNext[3:0] == s.info.dummy) begin
                  next_s.cnt = 5'h00;
                  next_s.st = ST_RDATA;
               end
            end
         end
         ST_WDATA: begin
            if (rise) begin
               next_s.sh = shNext;
               next_s.cnt = cntNext;
               if (cntNext == BYTE_BITS) begin
                  next_s.cnt = 5'h00;
                  next_s.gotByte = 1'b1;
                  if (s.info.kind == K_WSTAT) begin
                     next_s.stData = shNext[7:0];
                  end else if (s.gotByte) begin
                     // program data wraps within the 256-byte page
                     next_s.addr[7:0] = s.addr[7:0] + 8'h01;
                  end
                  if (s.info.kind == K_PROG) begin
                     next_s.wrByte = shNext[7:0];
                     next_s.wrValid = 1'b1;
                  end
               end
            end
         end
         ST_RDATA: begin
            if (fall) begin
               next_s.ioOut = laneOut(outByte, s.info.dLanes);
               next_s.ioOe = laneMask(s.info.dLanes);
               next_s.outSh = outByte << s.info.dLanes;
               next_s.outCnt = s.outCnt + s.info.dLanes;
               if (s.outCnt + s.info.dLanes == 3'h0 && s.info.kind == K_READ) begin
                  next_s.addr = s.addr + 24'h1; // byte fully sent
               end
            end
         end
         ST_DONE, ST_SKIP: begin
            // extra clocks after a complete or refused instruction carry no meaning
         end
         default: next_s.st = ST_CMD;
      endcase

      // ------------------------------------------------------------
      // execution on deselect; incomplete instructions are dropped
      // ------------------------------------------------------------
      if (deselect) begin
         next_s.st = ST_CMD;
         next_s.cnt = 5'h00;
         next_s.sh = 32'h0;
         next_s.outCnt = 3'h0;
         next_s.ioOe = 4'h0;
         if (s.st == ST_DONE && s.op == OP_WREN) begin
            next_s.wen = 1'b1;
         end else if (s.st == ST_DONE && s.op == OP_WRDI) begin
            next_s.wen = 1'b0;
         end else if (s.st == ST_DONE && s.op == OP_PDOWN) begin
            next_s.pd = 1'b1;
         end else if (s.st == ST_DONE && s.op == OP_RPD) begin
            next_s.pd = 1'b0;
         end else if ((s.st == ST_DONE && s.info.kind == K_ERASE &&
            !((s.op == OP_CE) ? protAny : protHit)) ||
            (s.st == ST_WDATA && s.cnt == 5'h00 && s.gotByte &&
            ((s.info.kind == K_PROG && !protHit) ||
            (s.info.kind == K_WSTAT && statusWriteOk)))) begin
            next_s.cmd = '{valid: 1'b1, opcode: s.op, addr: s.addr, data: s.stData};
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s <= RESET_S;
      end else begin
         s <= next_s;
      end
   end

   assign ioOut = s.ioOut;
   assign ioOe = s.ioOe;
   assign readAddr = s.addr;
   assign wrByte = s.wrByte;
   assign wrByteValid = s.wrValid;
   assign cmd = s.cmd;
   assign writeEnableLatch = s.wen;
   assign poweredDown = s.pd;
   assign writeInhibit = s.inhibit;
   assign paused = holdPaused;

endmodule : sfspi_front

// ==== sfspi_pkg.sv ====
// sfspi_pkg: constants and types of the serial flash interface front end.
// assumes one 250 MHz clock; all pins are sampled as synchronous inputs.
package sfspi_pkg;

   // ------------------------------------------------------------
   // instruction codes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST = 8'h0b;
   localparam logic [7:0] OP_DOUT = 8'h3b;
   localparam logic [7:0] OP_DIO = 8'hbb;
   localparam logic [7:0] OP_QOUT = 8'h6b;
   localparam logic [7:0] OP_QIO = 8'heb;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_SE4 = 8'h20;
   localparam logic [7:0] OP_BE32 = 8'h52;
   localparam logic [7:0] OP_BE64 = 8'hd8;
   localparam logic [7:0] OP_CE = 8'hc7;
   localparam logic [7:0] OP_PDOWN = 8'hb9;
   localparam logic [7:0] OP_RPD = 8'hab;

   // ------------------------------------------------------------
   // widths, lanes, timing
   // ------------------------------------------------------------
   localparam int ADDR_W = 24;
   localparam int ARRAY_W = 19;
   localparam logic [18:0] ARRAY_BYTES = 19'h40000;
   localparam logic [18:0] SECTOR_BYTES = 19'h01000;
   localparam logic [18:0] BLOCK_BYTES = 19'h10000;
   localparam logic [4:0] ADDR_BITS = 5'h18;
   localparam logic [4:0] BYTE_BITS = 5'h08;
   localparam logic [2:0] LANE_X1 = 3'h1;
   localparam logic [2:0] LANE_X2 = 3'h2;
   localparam logic [2:0] LANE_X4 = 3'h4;
   localparam logic [3:0] DUMMY_NONE = 4'h0;
   localparam logic [3:0] DUMMY_FAST = 4'h8;
   localparam logic [3:0] DUMMY_DIO = 4'h4;
   localparam logic [3:0] DUMMY_QIO = 4'h6;
   localparam int BUSY_POS = 0;
   localparam int WEN_POS = 1;
   localparam int CLK_MHZ = 250;
   localparam int PUW_DELAY_US = 10;
   localparam int PUW_CYCLES = PUW_DELAY_US * CLK_MHZ;
   localparam int PUW_W = 16;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_CMD = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_DONE = 3'b101,
      ST_SKIP = 3'b110
   } sfspi_state_type;

   typedef enum logic [2:0] {
      K_NONE = 3'b000,
      K_CTRL = 3'b001,
      K_READ = 3'b010,
      K_STAT = 3'b011,
      K_WSTAT = 3'b100,
      K_PROG = 3'b101,
      K_ERASE = 3'b110
   } sfspi_kind_type;

   typedef struct packed {
      sfspi_kind_type kind;
      logic [2:0] aLanes;
      logic [3:0] dummy;
      logic [2:0] dLanes;
      logic needWen;
      logic needQuad;
   } sfspi_opinfo_type;

   typedef struct packed {
      logic complement;
      logic granularity;
      logic topBottom;
      logic [2:0] range;
   } sfspi_prot_type;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] data;
   } sfspi_cmd_type;

endpackage : sfspi_pkg

// ==== sfspi_hold.sv ====
// sfspi_hold: pause tracking for the serial link.
// assumes serial clock and pause pin sampled as synchronous inputs.
module sfspi_hold
   import sfspi_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic csN,
   input wire logic holdN,
   input wire logic enable,
   output logic paused
);

   typedef struct packed {
      logic paused;
      logic holdPrev;
      logic sclkPrev;
   } sfspi_hold_type;

   sfspi_hold_type s;
   sfspi_hold_type next_s;

   always_comb begin
      next_s = s;
      next_s.holdPrev = holdN;
      next_s.sclkPrev = sclk;
      if (csN || !enable) begin
         // deselect drops the pause together with the instruction
         next_s.paused = 1'b0;
      end else if (!sclk && ((holdN != s.holdPrev) || s.sclkPrev)) begin
         // pin edge while clock low, or first low sample after a fall
         next_s.paused = !holdN;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s <= '{paused: 1'b0, holdPrev: 1'b1, sclkPrev: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign paused = s.paused;

endmodule : sfspi_hold

// ==== sfspi_protect.sv ====
// sfspi_protect: array protection lookup from the block protect settings.
// purely combinational; the caller registers its results.
module sfspi_protect
   import sfspi_pkg::*;
(
   input wire logic [ARRAY_W-1:0] addr,
   input wire sfspi_prot_type prot,
   output logic hit,
   output logic anyHit
);

   logic [ARRAY_W-1:0] span;
   logic inRange;

   always_comb begin
      span = '0;
      if (prot.range != 3'h0) begin
         if (prot.granularity) begin
            // sector granularity stops at eight sectors
            span = (prot.range > 3'h3) ? (SECTOR_BYTES << 3) :
               (SECTOR_BYTES << (prot.range - 3'h1));
         end else begin
            span = (prot.range > 3'h2) ? ARRAY_BYTES :
               (BLOCK_BYTES << (prot.range - 3'h1));
         end
      end
      if (prot.topBottom) begin
         inRange = addr < span;
      end else begin
         inRange = addr >= (ARRAY_BYTES - span);
      end
      hit = inRange ^ prot.complement;
      anyHit = prot.complement ? (span != ARRAY_BYTES) : (span != '0);
   end

endmodule : sfspi_protect

// ==== sfspi_front_asserts.sv ====
// sfspi_front_asserts: port timing relations of the link front end.
// assumes it is bound to sfspi_front and sees only its ports.
module sfspi_front_asserts
   import sfspi_pkg::*;
#(
   parameter int PUW_COUNT = PUW_CYCLES
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic csN,
   input wire logic quadEnable,
   input wire logic opDone,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe,
   input wire logic wrByteValid,
   input wire sfspi_cmd_type cmd,
   input wire logic writeEnableLatch,
   input wire logic poweredDown,
   input wire logic writeInhibit,
   input wire logic paused
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   logic [15:0] puwCnt;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         puwCnt <= 16'h0000;
      end else if (writeInhibit) begin
         puwCnt <= puwCnt + 16'h0001;
      end
   end
   // enables drop one cycle after the cause, hence three samples
   sequence sIdle;
      csN [*3];
   endsequence
   sequence sHeld;
      paused [*3];
   endsequence
   AST_DESELECT_FLOAT: assert property (sIdle |-> ioOe == 4'h0)
      else $error("enabled while deselected");
   AST_PAUSE_FLOAT: assert property (sHeld |-> ioOe == 4'h0)
      else $error("enabled while paused");
   AST_POWERUP: assert property ($rose(rst_b) |-> !writeEnableLatch && writeInhibit)
      else $error("bad state after reset");
   AST_PUW_SPAN: assert property ($fell(writeInhibit)
      |-> puwCnt >= PUW_COUNT - 1 && puwCnt <= PUW_COUNT + 2)
      else $error("write delay length wrong");
   AST_DONE_CLEARS: assert property (opDone && csN && $past(csN) |=> !writeEnableLatch)
      else $error("latch kept after done");
   AST_OUT_ON_FALL: assert property ($changed(ioOut) |-> $past(sclk, 2) && !$past(sclk))
      else $error("output moved off a fall");
   AST_BYTE_ON_RISE: assert property (wrByteValid |-> $past(sclk) && !$past(sclk, 2))
      else $error("byte not after a rise");
   AST_QUAD_GATED: assert property ((!quadEnable) [*2] |-> ioOe[3:2] == 2'b00)
      else $error("quad lanes without enable");
   AST_SLEEP_SILENT: assert property (poweredDown && $past(poweredDown) |-> !cmd.valid)
      else $error("command in power-down");
endmodule : sfspi_front_asserts

bind sfspi_front sfspi_front_asserts #(.PUW_COUNT(PUW_COUNT)) u_chk (
   .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .csN(csN), .quadEnable(quadEnable),
   .opDone(opDone), .ioOut(ioOut), .ioOe(ioOe), .wrByteValid(wrByteValid), .cmd(cmd),
   .writeEnableLatch(writeEnableLatch), .poweredDown(poweredDown),
   .writeInhibit(writeInhibit), .paused(paused)
);

// ==== sfspi_master_model.sv ====
// sfspi_master_model: link master in mode 0 or 3, HALF mclk per clock phase.
// assumes the bench resolves pin levels from the device enables.
module sfspi_master_model #(
   parameter int HALF = 2
)
(
   input wire logic mclk,
   input wire logic [3:0] ioPin,
   output logic sclk,
   output logic csN,
   output logic [3:0] io
);
   timeunit 1ns;
   timeprecision 1ps;
   logic idle = 1'b0;
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      io = 4'hc;
   end
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(negedge mclk);
         sclk = 1'b0;
         io[0] = tx[i];
         repeat (HALF) @(negedge mclk);
         sclk = 1'b1;
         rx[i] = ioPin[1];
         repeat (HALF - 1) @(negedge mclk);
      end
   endtask : xfer
   task automatic start();
      @(negedge mclk);
      sclk = idle;
      @(negedge mclk);
      csN = 1'b0;
   endtask : start
   task automatic done();
      @(negedge mclk);
      sclk = idle;
      repeat (HALF) @(negedge mclk);
      csN = 1'b1;
      // released lines flip so stale data cannot pass
      io[1:0] = ~io[1:0];
      repeat (HALF) @(negedge mclk);
   endtask : done
endmodule : sfspi_master_model

// ==== sfspi_front_tb_top.sv ====
// sfspi_front_tb_top: self-checking bench of the link front end.
// assumes the master model drives the link; array engine modelled here.
module sfspi_front_tb_top
   import sfspi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PUW = 200;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic quadEnable = 1'b0;
   logic statusProtectBit = 1'b0;
   logic opDone = 1'b0;
   logic qSeen = 1'b0;
   sfspi_prot_type prot = '0;
   logic sclk, csN, wrByteValid, write_enable_latch, poweredDown, writeInhibit, paused;
   logic [3:0] io, ioPin, ioOut, ioOe;
   logic [7:0] readData, rx, wb, wrByte;
   logic [ADDR_W-1:0] readAddr;
   sfspi_cmd_type cmd, lastCmd;
   int errorCnt = 0;
   int testsRun = 0;
   int cmdCnt = 0;
   assign ioPin = (ioOe & ioOut) | (~ioOe & io);
   assign readData = readAddr[7:0] ^ 8'h3c;
   initial begin
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (cmd.valid === 1'b1) begin
         cmdCnt++;
         lastCmd = cmd;
      end
      if (wrByteValid === 1'b1) wb = wrByte;
      if (ioOe[3] === 1'b1) qSeen = 1'b1;
   end
   sfspi_master_model #(.HALF(2)) m (
      .mclk(mclk), .ioPin(ioPin), .sclk(sclk), .csN(csN), .io(io)
   );
   sfspi_front #(.PUW_COUNT(PUW)) dut (
      .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .csN(csN), .ioIn(ioPin), .ioOut(ioOut),
      .ioOe(ioOe), .quadEnable(quadEnable), .statusProtectBit(statusProtectBit),
      .statusLockBit(1'b0), .prot(prot), .busy(1'b0), .opDone(opDone),
      .readData(readData), .readAddr(readAddr), .wrByte(wrByte), .wrByteValid(wrByteValid),
      .cmd(cmd), .writeEnableLatch(write_enable_latch), .poweredDown(poweredDown),
      .writeInhibit(writeInhibit), .paused(paused)
   );
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errorCnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic send(input logic [7:0] q[$]);
      m.start();
      foreach (q[i]) m.xfer(q[i], rx);
      m.done();
   endtask : send
   task automatic wsend(input logic [7:0] q[$]);
      send({OP_WREN});
      send(q);
   endtask : wsend
   task automatic results();
      $display("checks %0d errors %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // watchdog: roughly ten times the expected run
   initial begin
      #100000;
      errorCnt++;
      results();
   end
   initial begin
      repeat (20) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      check(ioOe, 4'h0);
      check(writeInhibit, 1'b1);
      send({OP_WREN});
      check(write_enable_latch, 1'b0);
      repeat (PUW) @(negedge mclk);
      m.idle = 1'b1;
      send({OP_WREN});
      check(write_enable_latch, 1'b1);
      m.idle = 1'b0;
      opDone = 1'b1;
      @(negedge mclk);
      opDone = 1'b0;
      @(negedge mclk);
      check(write_enable_latch, 1'b0);
      send({OP_PROG, 8'h00, 8'h01, 8'h00, 8'ha5});
      check(cmdCnt, 0);
      wsend({OP_PROG, 8'h00, 8'h01, 8'h00, 8'h5a});
      check(wb, 8'h5a);
      check(lastCmd.addr, 24'h000100);
      prot = 6'b010001;
      wsend({OP_SE4, 8'h03, 8'hf0, 8'h00});
      check(cmdCnt, 1);
      wsend({OP_SE4, 8'h00, 8'h00, 8'h00});
      check(lastCmd.opcode, OP_SE4);
      prot = '0;
      statusProtectBit = 1'b1;
      m.io[2] = 1'b0;
      wsend({OP_WRSR, 8'h00});
      check(cmdCnt, 2);
      m.io[2] = 1'b1;
      wsend({OP_WRSR, 8'h80});
      check(lastCmd.opcode, OP_WRSR);
      check(lastCmd.data, 8'h80);
      statusProtectBit = 1'b0;
      send({OP_RDSR, 8'h00});
      check(rx, 8'h02);
      send({OP_READ, 8'h00, 8'h00, 8'h40, 8'h00});
      check(rx, 8'h7c);
      send({OP_QOUT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      check(qSeen, 1'b0);
      quadEnable = 1'b1;
      send({OP_QOUT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      check(qSeen, 1'b1);
      quadEnable = 1'b0;
      send({OP_WREN});
      m.start();
      for (int i = 3; i >= 0; i--) m.xfer(i == 3 ? OP_PROG : (i == 1 ? 8'h02 : 8'h00), rx);
      m.sclk = 1'b0;
      repeat (2) @(negedge mclk);
      m.io[3] = 1'b0;
      repeat (3) @(negedge mclk);
      check(paused, 1'b1);
      m.sclk = 1'b1;
      repeat (3) @(negedge mclk);
      check(ioOe, 4'h0);
      m.sclk = 1'b0;
      repeat (3) @(negedge mclk);
      m.io[3] = 1'b1;
      repeat (3) @(negedge mclk);
      check(paused, 1'b0);
      m.xfer(8'h3e, rx);
      m.done();
      check(wb, 8'h3e);
      check(lastCmd.addr, 24'h000200);
      opDone = 1'b1;
      @(negedge mclk);
      opDone = 1'b0;
      send({OP_PDOWN});
      check(poweredDown, 1'b1);
      send({OP_WREN});
      check(write_enable_latch, 1'b0);
      send({OP_RPD});
      check(poweredDown, 1'b0);
      results();
   end
endmodule : sfspi_front_tb_top
